// ===== hdl/svp_i2c_regs.v
// Purpose: Serial-bus slave and register bank of the sound processor.
// Assumes: Bus clock well below a quarter of i_clock; i_rst is power-on reset.
// Notes:   Data line is open drain: o_sda_oe high pulls the line low.
// What this block does
// - Answer address 1000010 and acknowledge bytes.
// - Read returns one status byte, flags on top.
// - Power-on flag set by any power reset.
// - Successful status read clears power-on flag.
// - Two flags encode mono, dual, stereo, invalid.
// - Write is address, subaddress, then data.
// - Unused subaddress byte acknowledged, then discarded.
// - Route byte selects mute, mono, stereo, external.
// - Dual route codes pick second pair sources.
// - Input B gain in half-dB steps.
// - Input A trim in tenth-dB steps.
// - Integrator byte: bit1 enable, bit0 short.
// - Enable bit switches identification integrator on.
// - Short bit halves integration time to 0.5 s.
// - Subaddress 05h to FFh gets no acknowledge.
// - Successive data bytes go to next subaddress.
// - Power reset zeroes gain, trim and integrator.
`timescale 1ns/1ps
`default_nettype none
`include "svp_defines.vh"

module svp_i2c_regs #(
   parameter [23:0] P_INTEG_LONG_CYCLES =
      `SVP_INTEG_LONG_CYCLES,
   parameter [23:0] P_INTEG_SHORT_CYCLES =
      `SVP_INTEG_SHORT_CYCLES
) (
   // Clock and power-on reset.
   input wire i_clock,
   input wire i_rst,
   // Serial bus pins.
   input wire i_scl,
   input wire i_sda,
   output wire o_sda_out,
   output reg o_sda_oe,
   // Supply breakdown detector, asynchronous level.
   input wire i_supply_fail,
   // Identification detector flags, same clock domain.
   input wire i_matrix_ident_flag,
   input wire i_bilingual_ident_flag,
   // Stored register fields.
   output reg [6:0] o_route_select_bits,
   output reg [3:0] o_gain_b_bits,
   output reg [5:0] o_trim_a_bits,
   output reg o_integrator_on,
   output reg o_integrate_short,
   output reg o_power_on_flag,
   // Decoded audio settings.
   output wire [11:0] o_sources,
   output wire [3:0] o_gain_b_half_db,
   output wire [5:0] o_trim_a_tenth_db,
   // Transmission mode and integration period tick.
   output reg [1:0] o_mode,
   output reg o_integ_tick
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_SUB = 3'h2;
   localparam [2:0] ST_DATA = 3'h3;
   localparam [2:0] ST_READ = 3'h4;
   localparam [2:0] ST_IGNORE = 3'h5;
   localparam [1:0] INTEG_RST = `SVP_INTEG_RESET;

   wire scl_s;
   wire sda_s;
   wire fail_s;
   reg scl_d;
   reg sda_d;
   reg fail_d;
   reg [2:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] rx_shift;
   reg [7:0] tx_shift;
   reg [7:0] ptr;
   reg master_ack;
   reg read_done;
   reg [23:0] integ_cnt;
   wire scl_rise;
   wire scl_fall;
   wire start_cond;
   wire stop_cond;
   wire fail_rise;
   wire [7:0] status_byte;

   // The line is only ever pulled low.
   assign o_sda_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge detection.

   // Bus pins idle high, supply fail idles low.
   svp_sync #(.W(2), .IDLE(2'h3)) u_bus_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async({i_scl, i_sda}),
      .o_sync({scl_s, sda_s})
   );

   svp_sync #(.W(1), .IDLE(1'b0)) u_fail_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(i_supply_fail),
      .o_sync(fail_s)
   );

   // Previous synchronised levels.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         fail_d <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         fail_d <= fail_s;
      end
   end

   // Bus events; start and stop only while the clock stays high.
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
   assign fail_rise = fail_s & ~fail_d;

   // Status byte with zero low bits.
   assign status_byte = {o_power_on_flag, i_matrix_ident_flag,
      i_bilingual_ident_flag, 5'h00};

   ////////////////////////////////////////////////////////////////////////
   // Bus protocol engine and register writes.

   // Bit count runs 0..7 for data bits and 8 for the acknowledge clock.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         rx_shift <= 8'h00;
         tx_shift <= 8'h00;
         ptr <= 8'h00;
         master_ack <= 1'b0;
         read_done <= 1'b0;
         o_sda_oe <= 1'b0;
         o_route_select_bits <= `SVP_ROUTE_RESET;
         o_gain_b_bits <= `SVP_GAIN_B_RESET;
         o_trim_a_bits <= `SVP_TRIM_A_RESET;
         o_integrator_on <= INTEG_RST[`SVP_INTEG_ON_BIT];
         o_integrate_short <= INTEG_RST[`SVP_INTEG_SHORT_BIT];
      end else begin
         read_done <= 1'b0;
         if (start_cond) begin
            // A start resets the transceiver, also as repeated start.
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            o_sda_oe <= 1'b0;
         end else if (stop_cond) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            o_sda_oe <= 1'b0;
         end else if (state != ST_IDLE && state != ST_IGNORE) begin
            if (scl_rise) begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt < 4'h8) begin
                  rx_shift <= {rx_shift[6:0], sda_s};
               end else if (bit_cnt == 4'h8 && state == ST_READ && !o_sda_oe) begin
                  // Master clocked out a status byte; the address ack still holds the line.
                  master_ack <= ~sda_s;
                  read_done <= 1'b1;
               end
            end else if (scl_fall) begin
               if (bit_cnt == 4'h8) begin
                  case (state)
                     ST_ADDR: begin
                        if (rx_shift[7:1] == `SVP_SLAVE_ADDR) begin
                           o_sda_oe <= 1'b1;
                           master_ack <= 1'b1;
                           if (rx_shift[0]) begin
                              state <= ST_READ;
                           end else begin
                              state <= ST_SUB;
                           end
                        end else begin
                           state <= ST_IGNORE;
                        end
                     end
                     ST_SUB: begin
                        if (rx_shift <= `SVP_SUB_INTEG) begin
                           ptr <= rx_shift;
                           o_sda_oe <= 1'b1;
                           state <= ST_DATA;
                        end else begin
                           state <= ST_IGNORE;
                        end
                     end
                     ST_DATA: begin
                        if (ptr <= `SVP_SUB_INTEG) begin
                           o_sda_oe <= 1'b1;
                           ptr <= ptr + 8'h01;
                           if (ptr == `SVP_SUB_ROUTE) begin
                              o_route_select_bits <= rx_shift[6:0];
                           end else if (ptr == `SVP_SUB_GAIN_B) begin
                              o_gain_b_bits <= rx_shift[3:0];
                           end else if (ptr == `SVP_SUB_TRIM_A) begin
                              o_trim_a_bits <= rx_shift[5:0];
                           end else if (ptr == `SVP_SUB_INTEG) begin
                              o_integrator_on <= rx_shift[`SVP_INTEG_ON_BIT];
                              o_integrate_short <= rx_shift[`SVP_INTEG_SHORT_BIT];
                           end
                        end else begin
                           state <= ST_IGNORE;
                        end
                     end
                     default: begin
                        // Release the line so the master can acknowledge.
                        o_sda_oe <= 1'b0;
                     end
                  endcase
               end else if (bit_cnt == 4'h9) begin
                  bit_cnt <= 4'h0;
                  if (state == ST_READ) begin
                     if (master_ack) begin
                        tx_shift <= {status_byte[6:0], 1'b0};
                        o_sda_oe <= ~status_byte[7];
                     end else begin
                        o_sda_oe <= 1'b0;
                        state <= ST_IGNORE;
                     end
                  end else begin
                     o_sda_oe <= 1'b0;
                  end
               end else if (state == ST_READ) begin
                  // Next status bit, most significant first.
                  o_sda_oe <= ~tx_shift[7];
                  tx_shift <= {tx_shift[6:0], 1'b0};
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-on flag and transmission mode.

   // A supply breakdown in the same cycle as a read keeps the flag set.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_power_on_flag <= 1'b1;
      end else if (fail_rise) begin
         o_power_on_flag <= 1'b1;
      end else if (read_done) begin
         o_power_on_flag <= 1'b0;
      end
   end

   // Registered mode code from the detector flags.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_mode <= `SVP_MODE_MONO;
      end else begin
         o_mode <= {i_matrix_ident_flag, i_bilingual_ident_flag};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Integration period timer.

   // Ticks once per period while enabled; period follows the short bit.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         integ_cnt <= 24'h00_0000;
         o_integ_tick <= 1'b0;
      end else if (!o_integrator_on) begin
         integ_cnt <= 24'h00_0000;
         o_integ_tick <= 1'b0;
      end else if (integ_cnt + 24'h00_0001 >= (o_integrate_short ?
            P_INTEG_SHORT_CYCLES : P_INTEG_LONG_CYCLES)) begin
         integ_cnt <= 24'h00_0000;
         o_integ_tick <= 1'b1;
      end else begin
         integ_cnt <= integ_cnt + 24'h00_0001;
         o_integ_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Audio setting decode.

   svp_audio_decode u_decode (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_route_select_bits(o_route_select_bits),
      .i_gain_b_bits(o_gain_b_bits),
      .i_trim_a_bits(o_trim_a_bits),
      .o_sources(o_sources),
      .o_gain_b_half_db(o_gain_b_half_db),
      .o_trim_a_tenth_db(o_trim_a_tenth_db)
   );

endmodule

`default_nettype wire

// ===== include/svp_defines.vh
// Purpose: Shared constants of the sound processor control interface.
// Assumes: Included by bare name from every design file except the synchroniser.
// Notes:   Definitions only.
`ifndef SVP_DEFINES_VH
`define SVP_DEFINES_VH

// Serial bus address, seven bits, read/write bit excluded.
`define SVP_SLAVE_ADDR 7'h42
// Subaddresses of the write registers.
`define SVP_SUB_ROUTE 8'h00
`define SVP_SUB_UNUSED 8'h01
`define SVP_SUB_GAIN_B 8'h02
`define SVP_SUB_TRIM_A 8'h03
`define SVP_SUB_INTEG 8'h04
// Status byte field positions.
`define SVP_STAT_POWER_BIT 7
`define SVP_STAT_MATRIX_BIT 6
`define SVP_STAT_BILING_BIT 5
// Integrator control field positions.
`define SVP_INTEG_ON_BIT 1
`define SVP_INTEG_SHORT_BIT 0
// Reset values.
`define SVP_ROUTE_RESET 7'h00
`define SVP_GAIN_B_RESET 4'h0
`define SVP_TRIM_A_RESET 6'h00
`define SVP_INTEG_RESET 2'h0
// Transmission mode codes, {matrix, bilingual}.
`define SVP_MODE_MONO 2'h0
`define SVP_MODE_DUAL 2'h1
`define SVP_MODE_STEREO 2'h2
`define SVP_MODE_INVALID 2'h3
// Route selection codes.
`define SVP_RT_MUTE 7'h00
`define SVP_RT_MONO 7'h10
`define SVP_RT_STEREO 7'h2a
`define SVP_RT_DUAL_AA 7'h12
`define SVP_RT_DUAL_AB 7'h1a
`define SVP_RT_DUAL_BA 7'h16
`define SVP_RT_DUAL_BB 7'h1e
`define SVP_RT_EXT 7'h7a
// Output source codes.
`define SVP_SRC_MUTE 3'h0
`define SVP_SRC_MONO 3'h1
`define SVP_SRC_LEFT 3'h2
`define SVP_SRC_RIGHT 3'h3
`define SVP_SRC_A 3'h4
`define SVP_SRC_B 3'h5
`define SVP_SRC_EXT 3'h6
// Integration periods in clocks at 10 MHz: about 1 s and about 0.5 s.
`define SVP_INTEG_LONG_CYCLES 24'h98_9680
`define SVP_INTEG_SHORT_CYCLES 24'h4c_4b40

`endif

// ===== hdl/svp_sync.v
// Purpose: Two-stage synchroniser for pins from outside the clock domain.
// Assumes: Asynchronous active-high reset; idle level given by parameter.
// Notes:   Only the second stage is visible to other logic.
`timescale 1ns/1ps
`default_nettype none

module svp_sync #(
   parameter W = 1,
   parameter [W-1:0] IDLE = {W{1'b1}}
) (
   // Clock and reset.
   input wire i_clock,
   input wire i_rst,
   // Raw and synchronised levels.
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);

   reg [W-1:0] meta;

   // Two flip-flops in series.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta <= IDLE;
         o_sync <= IDLE;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end

endmodule

`default_nettype wire

// ===== hdl/svp_audio_decode.v
// Purpose: Turns the stored route and trim bytes into source and gain codes.
// Assumes: Register values come from the same clock domain.
// Notes:   Undefined codes give mute or 0 dB.
`timescale 1ns/1ps
`default_nettype none
`include "svp_defines.vh"

module svp_audio_decode (
   // Clock and reset.
   input wire i_clock,
   input wire i_rst,
   // Stored register fields.
   input wire [6:0] i_route_select_bits,
   input wire [3:0] i_gain_b_bits,
   input wire [5:0] i_trim_a_bits,
   // Source per output: main left, main right, second left, second right.
   output reg [11:0] o_sources,
   // Signed gain in half dB and trim in tenth dB.
   output reg [3:0] o_gain_b_half_db,
   output reg [5:0] o_trim_a_tenth_db
);

   // Four source codes packed main left first.
   function [11:0] route_decode;
      input [6:0] r;
      begin
         case (r)
            `SVP_RT_MONO: route_decode = {4{`SVP_SRC_MONO}};
            `SVP_RT_STEREO: route_decode = {`SVP_SRC_LEFT, `SVP_SRC_RIGHT,
               `SVP_SRC_LEFT, `SVP_SRC_RIGHT};
            `SVP_RT_DUAL_AA: route_decode = {`SVP_SRC_A, `SVP_SRC_B,
               `SVP_SRC_A, `SVP_SRC_A};
            `SVP_RT_DUAL_AB: route_decode = {`SVP_SRC_A, `SVP_SRC_B,
               `SVP_SRC_A, `SVP_SRC_B};
            `SVP_RT_DUAL_BA: route_decode = {`SVP_SRC_A, `SVP_SRC_B,
               `SVP_SRC_B, `SVP_SRC_A};
            `SVP_RT_DUAL_BB: route_decode = {`SVP_SRC_A, `SVP_SRC_B,
               `SVP_SRC_B, `SVP_SRC_B};
            `SVP_RT_EXT: route_decode = {4{`SVP_SRC_EXT}};
            default: route_decode = {4{`SVP_SRC_MUTE}};
         endcase
      end
   endfunction

   // Half-dB steps: 09h..0Dh positive, 01h..04h negative.
   function [3:0] gain_decode;
      input [3:0] g;
      begin
         if (g >= 4'h9 && g <= 4'hd) begin
            gain_decode = g - 4'h8;
         end else if (g >= 4'h1 && g <= 4'h4) begin
            gain_decode = 4'h0 - g;
         end else begin
            gain_decode = 4'h0;
         end
      end
   endfunction

   // Tenth-dB steps: 21h..39h positive, 01h..18h negative.
   function [5:0] trim_decode;
      input [5:0] t;
      begin
         if (t >= 6'h21 && t <= 6'h39) begin
            trim_decode = t - 6'h20;
         end else if (t >= 6'h01 && t <= 6'h18) begin
            trim_decode = 6'h00 - t;
         end else begin
            trim_decode = 6'h00;
         end
      end
   endfunction

   // Registered decode outputs.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_sources <= {4{`SVP_SRC_MUTE}};
         o_gain_b_half_db <= 4'h0;
         o_trim_a_tenth_db <= 6'h00;
      end else begin
         o_sources <= route_decode(i_route_select_bits);
         o_gain_b_half_db <= gain_decode(i_gain_b_bits);
         o_trim_a_tenth_db <= trim_decode(i_trim_a_bits);
      end
   end

endmodule

`default_nettype wire

// ===== bench/svp_host.sv
// Purpose: Bus master partner that drives the serial pins of the block.
// Assumes: Pull-up on the data line; one bus clock is eight system clocks.
// Notes:   Pins change one nanosecond after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module svp_host (
   // Clock.
   input wire logic i_clock,
   // Device pull-down enable.
   input wire logic i_sda_oe,
   // Bus pins.
   output logic o_scl,
   output wire logic o_sda
);
   logic pull_low;

   ////////////////////////////////////////
   // Wired-AND data line: high unless a party pulls it low.
   assign o_sda = !(pull_low || i_sda_oe);
   // The bus clock idles high and stands still outside frames.
   initial begin
      o_scl = 1'b1;
      pull_low = 1'b0;
   end

   // Waits n clocks and lands just after the edge.
   task automatic wt(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask

   // Start: data falls while the clock is high.
   task automatic start();
      pull_low = 1'b1;
      wt(3);
   endtask

   // Stop: data rises while the clock is high.
   task automatic stop();
      o_scl = 1'b0;
      wt(2);
      pull_low = 1'b1;
      wt(3);
      o_scl = 1'b1;
      wt(2);
      pull_low = 1'b0;
      wt(4);
   endtask

   // One bus clock: five clocks low with data set, three high with sampling.
   task automatic bitx(input logic d, output logic q);
      o_scl = 1'b0;
      wt(2);
      pull_low = !d;
      wt(3);
      o_scl = 1'b1;
      wt(1);
      q = o_sda;
      wt(2);
   endtask

   // Eight bits most significant first, then the acknowledge bit.
   task automatic xfer(input logic [7:0] d, input logic mack,
         output logic [7:0] q, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], b);
         q[i] = b;
      end
      bitx(!mack, b);
      ack = !b;
   endtask
endmodule
`default_nettype wire

// ===== bench/svp_i2c_regs_chk.sv
// Purpose: Concurrent checks on the ports of the serial register bank.
// Assumes: One clock domain with asynchronous active-high reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none

module svp_i2c_regs_chk #(
   parameter [23:0] P_INTEG_LONG_CYCLES = 24'h98_9680,
   parameter [23:0] P_INTEG_SHORT_CYCLES = 24'h4c_4b40
) (
   // Clock, reset and inputs.
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_supply_fail,
   input wire logic i_matrix_ident_flag,
   input wire logic i_bilingual_ident_flag,
   // Outputs.
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic [6:0] o_route_select_bits,
   input wire logic [3:0] o_gain_b_bits,
   input wire logic [5:0] o_trim_a_bits,
   input wire logic o_integrator_on,
   input wire logic o_integrate_short,
   input wire logic o_power_on_flag,
   input wire logic [1:0] o_mode,
   input wire logic o_integ_tick
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   ////////////////////////////////////////
   // Pin behaviour, flags and stored fields.
   a_sda_low_only:
      assert property (o_sda_out == 1'b0) else $error("data output not low");
   a_oe_moves_low:
      assert property ($rose(o_sda_oe) || $fell(o_sda_oe) |-> !i_scl)
      else $error("data enable moved while bus clock high");
   a_oe_hold_high:
      assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
      else $error("data enable unstable in bus clock high");
   a_reset_values:
      assert property ($fell(i_rst) |-> o_power_on_flag && !o_sda_oe &&
         o_gain_b_bits == 4'h0 && o_trim_a_bits == 6'h00 &&
         !o_integrator_on && !o_integrate_short)
      else $error("wrong values after reset");
   a_supply_sets_flag:
      assert property ($rose(i_supply_fail) |-> ##[1:5] o_power_on_flag)
      else $error("supply fail did not set power flag");
   a_flag_clear_idle:
      assert property ($fell(o_power_on_flag) |-> !o_sda_oe)
      else $error("power flag cleared while driving");
   a_store_with_ack:
      assert property ($changed(o_route_select_bits) || $changed(o_gain_b_bits)
         || $changed(o_trim_a_bits) || $changed({o_integrator_on,
         o_integrate_short}) |-> $rose(o_sda_oe))
      else $error("field changed without acknowledge");
   a_mode_follows:
      assert property (!$past(i_rst) |-> o_mode ==
         $past({i_matrix_ident_flag, i_bilingual_ident_flag}))
      else $error("mode does not follow flags");
   a_tick_gated:
      assert property (o_integ_tick |-> $past(o_integrator_on))
      else $error("tick while integrator off");
   a_tick_single:
      assert property (o_integ_tick |=> !o_integ_tick [*8])
      else $error("tick too close to the previous one");
endmodule

bind svp_i2c_regs svp_i2c_regs_chk #(
   .P_INTEG_LONG_CYCLES(P_INTEG_LONG_CYCLES),
   .P_INTEG_SHORT_CYCLES(P_INTEG_SHORT_CYCLES)
) svp_i2c_regs_chk_i (
   .i_clock(i_clock),
   .i_rst(i_rst),
   .i_scl(i_scl),
   .i_supply_fail(i_supply_fail),
   .i_matrix_ident_flag(i_matrix_ident_flag),
   .i_bilingual_ident_flag(i_bilingual_ident_flag),
   .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe),
   .o_route_select_bits(o_route_select_bits),
   .o_gain_b_bits(o_gain_b_bits),
   .o_trim_a_bits(o_trim_a_bits),
   .o_integrator_on(o_integrator_on),
   .o_integrate_short(o_integrate_short),
   .o_power_on_flag(o_power_on_flag),
   .o_mode(o_mode),
   .o_integ_tick(o_integ_tick)
);
`default_nettype wire

// ===== bench/svp_i2c_regs_tb.sv
// Purpose: Self-checking bench for the serial register bank.
// Assumes: The partner model drives the bus; integration counts are short.
// Notes:   Random data comes from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
`include "svp_defines.vh"

module svp_i2c_regs_tb;
   localparam int LONG = 40;
   localparam int SHORT = 20;
   logic i_clock = 1'b0;
   logic i_rst;
   logic sfail;
   logic [1:0] idf;
   wire scl;
   wire sda;
   logic oe, sdo, ion, ish, pflag, tick;
   logic [6:0] route;
   logic [3:0] gain, ghd;
   logic [5:0] trim, ttd;
   logic [11:0] src;
   logic [1:0] mode;
   logic [7:0] dat [6];
   logic [6:0] rc [9] = '{7'h00, 7'h10, 7'h2a, 7'h12, 7'h1a, 7'h16, 7'h1e, 7'h7a, 7'h55};
   int err_total = 0;
   int num_checks = 0;

   always #50 i_clock = ~i_clock;

   svp_i2c_regs #(
      .P_INTEG_LONG_CYCLES(24'h00_0028),
      .P_INTEG_SHORT_CYCLES(24'h00_0014)
   ) svp_i2c_regs_i (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_scl(scl),
      .i_sda(sda),
      .o_sda_out(sdo),
      .o_sda_oe(oe),
      .i_supply_fail(sfail),
      .i_matrix_ident_flag(idf[1]),
      .i_bilingual_ident_flag(idf[0]),
      .o_route_select_bits(route),
      .o_gain_b_bits(gain),
      .o_trim_a_bits(trim),
      .o_integrator_on(ion),
      .o_integrate_short(ish),
      .o_power_on_flag(pflag),
      .o_sources(src),
      .o_gain_b_half_db(ghd),
      .o_trim_a_tenth_db(ttd),
      .o_mode(mode),
      .o_integ_tick(tick)
   );

   svp_host svp_host_i (
      .i_clock(i_clock),
      .i_sda_oe(oe),
      .o_scl(scl),
      .o_sda(sda)
   );

   ////////////////////////////////////////
   // Expected decodes: half-dB gain, tenth-dB trim, output sources.
   function automatic logic [3:0] fg(input logic [3:0] g);
      if (g >= 4'h9 && g <= 4'hd) return g - 4'h8;
      if (g >= 4'h1 && g <= 4'h4) return -g;
      return 4'h0;
   endfunction

   function automatic logic [5:0] ft(input logic [5:0] t);
      if (t >= 6'h21 && t <= 6'h39) return t - 6'h20;
      if (t >= 6'h01 && t <= 6'h18) return -t;
      return 6'h00;
   endfunction

   function automatic logic [11:0] fs(input logic [6:0] r);
      case (r)
         7'h10: return {4{3'h1}};
         7'h2a: return {2{3'h2, 3'h3}};
         7'h12: return {3'h4, 3'h5, 3'h4, 3'h4};
         7'h1a: return {2{3'h4, 3'h5}};
         7'h16: return {3'h4, 3'h5, 3'h5, 3'h4};
         7'h1e: return {3'h4, 3'h5, 3'h5, 3'h5};
         7'h7a: return {4{3'h6}};
         default: return 12'h000;
      endcase
   endfunction

   // Compares one value and reports a mismatch.
   task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   // Write frame: address, subaddress, then n bytes of dat; acks per byte.
   task automatic wr(input logic [7:0] ad, input logic [7:0] sb, input int n,
         output logic [7:0] ak);
      logic [7:0] x;
      ak = 8'h00;
      svp_host_i.start();
      svp_host_i.xfer(ad, 1'b0, x, ak[0]);
      svp_host_i.xfer(sb, 1'b0, x, ak[1]);
      for (int i = 0; i < n; i++) svp_host_i.xfer(dat[i], 1'b0, x, ak[i + 2]);
      svp_host_i.stop();
   endtask

   // Read frame: status byte acked by the master, sent again, then refused.
   task automatic rd(output logic [7:0] q, output logic [7:0] q2, output logic a);
      logic [7:0] x;
      logic n;
      svp_host_i.start();
      svp_host_i.xfer({`SVP_SLAVE_ADDR, 1'b1}, 1'b0, x, a);
      svp_host_i.xfer(8'hff, 1'b1, q, n);
      svp_host_i.xfer(8'hff, 1'b0, q2, n);
      svp_host_i.stop();
   endtask

   // Counts ticks over a 400-cycle window.
   task automatic cnt(output int c);
      c = 0;
      repeat (400) begin
         svp_host_i.wt(1);
         c += (tick === 1'b1);
      end
   endtask

   // Values that hold just after a power reset.
   task automatic rst_vals();
      chk("power_flag", 12'h001, pflag);
      chk("trims", 12'h000, {gain, trim, ion, ish});
      chk("sda_out", 12'h000, sdo);
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence.
   initial begin
      logic [7:0] q;
      logic [7:0] q2;
      logic [7:0] ak;
      logic a;
      int c;
      i_rst = 1'b1;
      sfail = 1'b0;
      idf = 2'h0;
      void'($urandom(32'h5af2_4118));
      svp_host_i.wt(12);
      i_rst = 1'b0;
      svp_host_i.wt(1);
      rst_vals();
      for (int k = 0; k < 4; k++) begin
         idf = k[1:0];
         rd(q, q2, a);
         chk("addr_ack", 12'h001, a);
         chk("status", {k == 0, k[1:0], 5'h00}, q);
         chk("status_again", {1'b0, k[1:0], 5'h00}, q2);
         chk("mode", k[1:0], mode);
         chk("power_flag", 12'h000, pflag);
      end
      repeat (6) begin
         foreach (dat[i]) dat[i] = 8'($urandom);
         wr({`SVP_SLAVE_ADDR, 1'b0}, `SVP_SUB_ROUTE, 6, ak);
         chk("acks", 12'h07f, ak);
         chk("route", dat[0][6:0], route);
         chk("gain", dat[2][3:0], gain);
         chk("trim", dat[3][5:0], trim);
         chk("integ", dat[4][1:0], {ion, ish});
         chk("gain_db", fg(dat[2][3:0]), ghd);
         chk("trim_db", ft(dat[3][5:0]), ttd);
      end
      foreach (rc[i]) begin
         dat[0] = {1'b0, rc[i]};
         wr({`SVP_SLAVE_ADDR, 1'b0}, `SVP_SUB_ROUTE, 1, ak);
         chk("sources", fs(rc[i]), src);
      end
      repeat (4) begin
         dat[0] = 8'($urandom);
         wr({`SVP_SLAVE_ADDR, 1'b0}, 8'($urandom_range(255, 5)), 1, ak);
         chk("sub_nack", 12'h001, ak);
         c = $urandom_range(127);
         if (c == `SVP_SLAVE_ADDR) c = c + 1;
         wr({c[6:0], 1'b0}, `SVP_SUB_ROUTE, 1, ak);
         chk("addr_nack", 12'h000, ak);
         chk("route_kept", 12'h055, route);
      end
      for (int k = 0; k < 4; k++) begin
         dat[0] = {6'($urandom), k[1:0]};
         wr({`SVP_SLAVE_ADDR, 1'b0}, `SVP_SUB_INTEG, 1, ak);
         cnt(c);
         chk("ticks", k[1] ? 400 / (k[0] ? SHORT : LONG) : 0, c);
      end
      sfail = 1'b1;
      svp_host_i.wt(8);
      chk("power_flag", 12'h001, pflag);
      sfail = 1'b0;
      rd(q, q2, a);
      chk("status", {1'b1, idf, 5'h00}, q);
      chk("status_again", {1'b0, idf, 5'h00}, q2);
      chk("power_flag", 12'h000, pflag);
      i_rst = 1'b1;
      svp_host_i.wt(3);
      i_rst = 1'b0;
      svp_host_i.wt(1);
      rst_vals();
      final_report();
   end

   // Watchdog well beyond the expected run length.
   initial begin
      #5000000;
      err_total++;
      final_report();
   end
endmodule
`default_nettype wire
